// *** inc/pctmr_regs.svh ***
// register offsets, field positions and reset values of the channel timer
// assumes: byte-wide register port, 8-bit addresses
`ifndef PCTMR_REGS_SVH
`define PCTMR_REGS_SVH

`define PCT_OFF_VAL0 8'h3A
`define PCT_OFF_VAL1 8'h3B
`define PCT_OFF_VAL2 8'h3C
`define PCT_OFF_CFG 8'h3D
`define PCT_OFF_CMD 8'h50
`define PCT_OFF_ISTAT 8'h51
`define PCT_OFF_IMASK 8'h52
`define PCT_OFF_STAT 8'h53

`define PCT_CFG_SRC_BIT 7
`define PCT_CFG_OWNER_BIT 4
`define PCT_CFG_CNT_HI 2
`define PCT_CFG_CNT_LO 0
`define PCT_CFG_MASK 8'h97
`define PCT_CNT_UNLIMITED 3'h7

`define PCT_CMD_START_BIT 0
`define PCT_CMD_STOP_BIT 1

`define PCT_IRQ_EXPIRY_BIT 0
`define PCT_IRQ_POLL_BIT 1
`define PCT_IRQ_EXHAUST_BIT 2
`define PCT_IRQ_W 3

`define PCT_RST_BYTE 8'h00
`define PCT_RST_VALUE 24'h000000

`endif

// *** inc/pctmr_pkg.sv ***
// types of the channel timer: run state and the state records of both modules
// assumes: pctmr_regs.svh is included by the top-level design file and the bench
`default_nettype none
package pctmr_pkg;

    typedef enum logic {PCT_IDLE, PCT_RUN} pctmr_run_e;

    typedef struct packed {
        logic [1:0][2:0] sh;
        logic [1:0] lvl;
        logic tick;
    } pctmr_tick_s;

    typedef struct packed {
        logic [23:0] value;
        logic src;
        logic owner;
        logic [2:0] cnt;
        pctmr_run_e run;
        logic [23:0] count;
        logic [2:0] rem;
        logic [2:0] ist;
        logic [2:0] imask;
        logic [7:0] rdata;
        logic poll;
    } pctmr_core_s;

endpackage
`default_nettype wire

// *** inc/pctmr_tick_if.sv ***
// carries the tick source choice to the tick selector and the tick back
// assumes: both ends run on MCLK
`timescale 1ns/10ps
`default_nettype none
interface pctmr_tick_if;
    logic use_fsync;
    logic tick;
    modport sel(input use_fsync, output tick);
    modport user(output use_fsync, input tick);
endinterface
`default_nettype wire

// *** hw/pctmr_tick_sel.sv ***
// filters the transmit clock and frame-sync pins and yields one tick per rising edge of the selected pin
// assumes: pins asynchronous to MCLK and slower than a quarter of it
`timescale 1ns/10ps
`default_nettype none
module pctmr_tick_sel
    import pctmr_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic txclk_pin,
    input wire logic fsync_pin,
    pctmr_tick_if.sel tif
);
    import pctmr_pkg::*;

    pctmr_tick_s q, d;
    logic [1:0] pin;

    assign pin = {fsync_pin, txclk_pin};

    always_comb begin
        d = q;
        for (int i = 0; i < 2; i++) begin
            d.sh[i][0] = pin[i];
            d.sh[i][1] = q.sh[i][0];
            d.sh[i][2] = q.sh[i][1];
            // a level only counts once the two later stages agree
            if (q.sh[i][1] == q.sh[i][2]) begin
                d.lvl[i] = q.sh[i][2];
            end
        end
        if (tif.use_fsync) begin
            d.tick = d.lvl[1] & ~q.lvl[1]; // see RL2
        end else begin
            d.tick = d.lvl[0] & ~q.lvl[0]; // see RL1
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tif.tick = q.tick;

endmodule
`default_nettype wire

// *** hw/pctmr_top.sv ***
// channel timer: 24-bit expiry counter with restart count, cpu and protocol-engine owner
// assumes: byte register port on MCLK; protocol engine strobes are MCLK pulses
// Operation
// RL1: source select 0 ticks the timer from the effective transmit clock.
// RL2: source select 1 ticks it from frame sync, only in clock mode 5.
// RL3: software sets owner select 1 only for automatic HDLC mode.
// RL4: cpu owner: start command starts the timer at any time.
// RL5: cpu owner: every expiry raises a timer interrupt.
// RL6: cpu owner: stop command halts the timer at any moment.
// RL7: engine owner: commands ignored; engine uses timer for time-outs and retries.
// RL8: engine owner: unacknowledged frame gets poll commands after time-outs, count-limited.
// RL9: engine owner: count 7 makes poll retries unlimited.
// RL10: cpu owner: timer restarts itself after expiry, count times.
// RL11: cpu owner: count 7 gives periodic interrupts without end.
// RL12: period is value plus one ticks; value bytes least significant first.
// RL13: configuration byte: source bit 7, owner bit 4, count bits 2..0.
// RL14: cpu owner: after the last counted expiry the timer stays stopped.
`timescale 1ns/10ps
`include "pctmr_regs.svh"
`default_nettype none
module pctmr_top
    import pctmr_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [7:0] RDATA,
    output logic IRQ,
    input wire logic TXCLK_EFF,
    input wire logic FRAME_SYNC_INPUT,
    input wire logic CLOCK_MODE5,
    input wire logic IFRAME_SENT,
    input wire logic ACK_RECEIVED,
    output logic POLL_REQ,
    output logic TIMER_RUNNING
);
    import pctmr_pkg::*;

    if (ADDR_W < 7 || ADDR_W > 16) begin : g_chk
        $error("pctmr_top: ADDR_W must lie in 7..16");
    end

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == ADDR_W'(off));
    endfunction

    pctmr_core_s q, d;
    pctmr_tick_if tif();
    logic tick;
    logic wr_cmd;
    logic cmd_start;
    logic cmd_stop;
    logic at_end;
    logic ev_exp;
    logic ev_poll;
    logic ev_exh;
    logic [2:0] ev;

    pctmr_tick_sel pctmr_tick_sel_i (
        .MCLK(MCLK),
        .SYS_RST(SYS_RST),
        .txclk_pin(TXCLK_EFF),
        .fsync_pin(FRAME_SYNC_INPUT),
        .tif(tif)
    );

    // source select has no meaning outside clock mode 5
    assign tif.use_fsync = q.src & CLOCK_MODE5; // see RL2
    assign tick = tif.tick;

    assign wr_cmd = WR_STB && hit(ADDR, `PCT_OFF_CMD);
    // the engine owns the timer in automatic mode, so cpu commands fall away
    assign cmd_start = wr_cmd && WDATA[`PCT_CMD_START_BIT] && !q.owner; // see RL4 see RL7
    assign cmd_stop = wr_cmd && WDATA[`PCT_CMD_STOP_BIT] && !q.owner; // see RL6 see RL7

    assign at_end = (q.run == PCT_RUN) && tick && (q.count == q.value); // see RL12
    assign ev_exp = at_end && !q.owner; // see RL5
    assign ev_poll = at_end && q.owner && (q.cnt == `PCT_CNT_UNLIMITED || q.rem != 3'h0);
    assign ev_exh = at_end && q.owner && !ev_poll;

    always_comb begin
        ev = '0;
        ev[`PCT_IRQ_EXPIRY_BIT] = ev_exp;
        ev[`PCT_IRQ_POLL_BIT] = ev_poll;
        ev[`PCT_IRQ_EXHAUST_BIT] = ev_exh;
    end

    always_comb begin
        d = q;
        d.poll = 1'b0;
        d.rdata = `PCT_RST_BYTE;

        // counting and expiry handling
        if (q.run == PCT_RUN && tick) begin
            if (q.count == q.value) begin
                d.count = '0;
                if (q.cnt == `PCT_CNT_UNLIMITED) begin
                    d.poll = q.owner; // see RL9 see RL11
                end else if (q.rem != 3'h0) begin
                    d.rem = q.rem - 3'h1; // see RL10 see RL8
                    d.poll = q.owner; // see RL8
                end else begin
                    d.run = PCT_IDLE; // see RL14
                end
            end else begin
                d.count = q.count + 24'h1;
            end
        end

        // protocol engine control in automatic mode
        if (q.owner) begin
            if (ACK_RECEIVED) begin
                d.run = PCT_IDLE; // see RL7
            end else if (IFRAME_SENT) begin
                d.run = PCT_RUN; // see RL7
                d.count = '0;
                d.rem = q.cnt;
            end
        end

        // stop wins over a start written in the same byte
        if (cmd_stop) begin
            d.run = PCT_IDLE; // see RL6
        end else if (cmd_start) begin
            d.run = PCT_RUN; // see RL4
            d.count = '0;
            d.rem = q.cnt;
        end

        if (WR_STB) begin
            if (hit(ADDR, `PCT_OFF_VAL0)) begin
                d.value[7:0] = WDATA; // see RL12
            end
            if (hit(ADDR, `PCT_OFF_VAL1)) begin
                d.value[15:8] = WDATA;
            end
            if (hit(ADDR, `PCT_OFF_VAL2)) begin
                d.value[23:16] = WDATA;
            end
            if (hit(ADDR, `PCT_OFF_CFG)) begin
                d.src = WDATA[`PCT_CFG_SRC_BIT]; // see RL13
                d.owner = WDATA[`PCT_CFG_OWNER_BIT];
                d.cnt = WDATA[`PCT_CFG_CNT_HI:`PCT_CFG_CNT_LO];
            end
            if (hit(ADDR, `PCT_OFF_IMASK)) begin
                d.imask = WDATA[`PCT_IRQ_W-1:0];
            end
        end

        // a read clears status, but an event in the same cycle survives
        if (RD_STB && hit(ADDR, `PCT_OFF_ISTAT)) begin
            d.ist = ev;
        end else begin
            d.ist = q.ist | ev;
        end

        if (RD_STB) begin
            if (hit(ADDR, `PCT_OFF_VAL0)) begin
                d.rdata = q.value[7:0];
            end
            if (hit(ADDR, `PCT_OFF_VAL1)) begin
                d.rdata = q.value[15:8];
            end
            if (hit(ADDR, `PCT_OFF_VAL2)) begin
                d.rdata = q.value[23:16];
            end
            if (hit(ADDR, `PCT_OFF_CFG)) begin
                d.rdata = {q.src, 2'b00, q.owner, 1'b0, q.cnt}; // see RL13
            end
            if (hit(ADDR, `PCT_OFF_ISTAT)) begin
                d.rdata = {5'h00, q.ist};
            end
            if (hit(ADDR, `PCT_OFF_IMASK)) begin
                d.rdata = {5'h00, q.imask};
            end
            if (hit(ADDR, `PCT_OFF_STAT)) begin
                d.rdata = {1'b0, q.rem, 3'h0, q.run == PCT_RUN};
            end
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            q.value <= `PCT_RST_VALUE;
            q.src <= 1'b0;
            q.owner <= 1'b0;
            q.cnt <= 3'h0;
            q.run <= PCT_IDLE;
            q.count <= 24'h000000;
            q.rem <= 3'h0;
            q.ist <= 3'h0;
            q.imask <= 3'h0;
            q.rdata <= `PCT_RST_BYTE;
            q.poll <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign RDATA = q.rdata;
    assign IRQ = |(q.ist & q.imask);
    assign POLL_REQ = q.poll;
    assign TIMER_RUNNING = (q.run == PCT_RUN);

    a_stop_halts: assert property ( // see RL6
        @(posedge MCLK) disable iff (SYS_RST)
        cmd_stop |=> (q.run == PCT_IDLE) && !TIMER_RUNNING)
        else $error("stop command did not halt the timer");

    a_start_runs: assert property ( // see RL4
        @(posedge MCLK) disable iff (SYS_RST)
        (cmd_start && !cmd_stop)
        |=> TIMER_RUNNING && (q.count == 24'h0) && (q.rem == $past(q.cnt)))
        else $error("start command did not load and run the timer");

    a_expiry_irq: assert property ( // see RL5
        @(posedge MCLK) disable iff (SYS_RST)
        (ev_exp && q.imask[`PCT_IRQ_EXPIRY_BIT]) |=> IRQ && q.ist[`PCT_IRQ_EXPIRY_BIT])
        else $error("expiry did not raise the interrupt");

    a_owner_ignores: assert property ( // see RL7
        @(posedge MCLK) disable iff (SYS_RST)
        (q.owner && wr_cmd && !tick && !ACK_RECEIVED && !IFRAME_SENT) |=> $stable(q.run))
        else $error("command acted while the engine owns the timer");

    a_period_len: assert property ( // see RL12
        @(posedge MCLK) disable iff (SYS_RST)
        (q.run == PCT_RUN && tick && q.count != q.value && !cmd_start && !q.owner)
        |=> (q.count == $past(q.count) + 24'h1) && !ev_exp)
        else $error("counter stepped wrongly before expiry");

    a_final_stop: assert property ( // see RL14
        @(posedge MCLK) disable iff (SYS_RST)
        (ev_exp && q.cnt != `PCT_CNT_UNLIMITED && q.rem == 3'h0 && !cmd_start)
        |=> !TIMER_RUNNING ##1 (!TIMER_RUNNING || $past(cmd_start)))
        else $error("timer kept running after its last expiry");

    a_restart_cnt: assert property ( // see RL10
        @(posedge MCLK) disable iff (SYS_RST)
        (ev_exp && q.cnt != `PCT_CNT_UNLIMITED && q.rem != 3'h0 && !cmd_stop && !cmd_start)
        |=> TIMER_RUNNING && (q.rem == $past(q.rem) - 3'h1) && (q.count == 24'h0))
        else $error("counted restart failed");

    a_periodic: assert property ( // see RL11
        @(posedge MCLK) disable iff (SYS_RST)
        (ev_exp && q.cnt == `PCT_CNT_UNLIMITED && !cmd_stop) |=> TIMER_RUNNING && !POLL_REQ)
        else $error("periodic timer stopped");

    a_poll_retry: assert property ( // see RL8
        @(posedge MCLK) disable iff (SYS_RST)
        (at_end && q.owner && q.rem != 3'h0 && !ACK_RECEIVED && !IFRAME_SENT)
        |=> POLL_REQ && TIMER_RUNNING ##1 !POLL_REQ)
        else $error("time-out did not request a poll retry");

    a_poll_endless: assert property ( // see RL9
        @(posedge MCLK) disable iff (SYS_RST)
        (at_end && q.owner && q.cnt == `PCT_CNT_UNLIMITED && !ACK_RECEIVED) |=> POLL_REQ)
        else $error("unlimited retries ended");

    a_cfg_zeros: assert property ( // see RL13
        @(posedge MCLK) disable iff (SYS_RST)
        (RD_STB && hit(ADDR, `PCT_OFF_CFG)) |=> (RDATA & ~`PCT_CFG_MASK) == 8'h00)
        else $error("reserved configuration bits read non-zero");

    // period counting relies on ticks never coming back to back
    a_tick_gap: assert property ( // see RL12
        @(posedge MCLK) disable iff (SYS_RST)
        tick |=> !tick)
        else $error("tick lasted more than one cycle");

    a_idle_holds: assert property ( // see RL6
        @(posedge MCLK) disable iff (SYS_RST)
        (q.run == PCT_IDLE && !cmd_start && !(q.owner && IFRAME_SENT))
        |=> $stable(q.count) && !TIMER_RUNNING)
        else $error("stopped timer moved");

    a_status_sticky: assert property ( // see RL5
        @(posedge MCLK) disable iff (SYS_RST)
        (q.ist[`PCT_IRQ_EXPIRY_BIT] && !(RD_STB && hit(ADDR, `PCT_OFF_ISTAT)))
        |=> q.ist[`PCT_IRQ_EXPIRY_BIT])
        else $error("expiry status lost without a read");

    a_read_clear: assert property ( // see RL5
        @(posedge MCLK) disable iff (SYS_RST)
        (RD_STB && hit(ADDR, `PCT_OFF_ISTAT) && ev == 3'h0) |=> (q.ist == 3'h0) && !IRQ)
        else $error("status read did not clear");

    a_value_byte0: assert property ( // see RL12
        @(posedge MCLK) disable iff (SYS_RST)
        (WR_STB && hit(ADDR, `PCT_OFF_VAL0)) |=> (q.value[7:0] == $past(WDATA)))
        else $error("low value byte not written");

    a_value_byte1: assert property ( // see RL12
        @(posedge MCLK) disable iff (SYS_RST)
        (WR_STB && hit(ADDR, `PCT_OFF_VAL1)) |=> (q.value[15:8] == $past(WDATA)))
        else $error("middle value byte not written");

    a_value_byte2: assert property ( // see RL12
        @(posedge MCLK) disable iff (SYS_RST)
        (WR_STB && hit(ADDR, `PCT_OFF_VAL2)) |=> (q.value[23:16] == $past(WDATA)))
        else $error("high value byte not written");

    a_cfg_write: assert property ( // see RL13
        @(posedge MCLK) disable iff (SYS_RST)
        (WR_STB && hit(ADDR, `PCT_OFF_CFG))
        |=> (q.src == $past(WDATA[`PCT_CFG_SRC_BIT]))
            && (q.owner == $past(WDATA[`PCT_CFG_OWNER_BIT]))
            && (q.cnt == $past(WDATA[`PCT_CFG_CNT_HI:`PCT_CFG_CNT_LO])))
        else $error("configuration fields not taken");

    a_poll_pulse: assert property ( // see RL8
        @(posedge MCLK) disable iff (SYS_RST)
        POLL_REQ |=> !POLL_REQ)
        else $error("poll request longer than one cycle");

    a_cpu_no_poll: assert property ( // see RL7
        @(posedge MCLK) disable iff (SYS_RST)
        (at_end && !q.owner) |=> !POLL_REQ)
        else $error("poll requested while the cpu owns the timer");

    a_poll_status: assert property ( // see RL8
        @(posedge MCLK) disable iff (SYS_RST)
        ev_poll |=> POLL_REQ && q.ist[`PCT_IRQ_POLL_BIT])
        else $error("poll retry not flagged");

    a_exhaust_stop: assert property ( // see RL8
        @(posedge MCLK) disable iff (SYS_RST)
        (at_end && q.owner && q.cnt != `PCT_CNT_UNLIMITED && q.rem == 3'h0
            && !ACK_RECEIVED && !IFRAME_SENT)
        |=> !TIMER_RUNNING && q.ist[`PCT_IRQ_EXHAUST_BIT])
        else $error("retries ran past the count");

    a_engine_start: assert property ( // see RL7
        @(posedge MCLK) disable iff (SYS_RST)
        (q.owner && IFRAME_SENT && !ACK_RECEIVED)
        |=> TIMER_RUNNING && (q.count == 24'h0) && (q.rem == $past(q.cnt)))
        else $error("sent frame did not start the time-out");

    a_ack_stops: assert property ( // see RL7
        @(posedge MCLK) disable iff (SYS_RST)
        (q.owner && ACK_RECEIVED) |=> !TIMER_RUNNING)
        else $error("acknowledge did not stop the time-out");

endmodule
`default_nettype wire

// *** test/pctmr_bench.sv ***
// self-checking bench of the channel timer: register port, cpu owner, engine owner
// assumes: pctmr_top with default ADDR_W, assertions live inside the design
`timescale 1ns/10ps
`include "pctmr_regs.svh"
`default_nettype none
module pctmr_bench;
    import pctmr_pkg::*;
    logic MCLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    logic WR_STB = 1'b0;
    logic RD_STB = 1'b0;
    logic [7:0] RDATA;
    logic IRQ;
    logic TXCLK_EFF = 1'b0;
    logic FRAME_SYNC_INPUT = 1'b0;
    logic CLOCK_MODE5 = 1'b0;
    logic IFRAME_SENT = 1'b0;
    logic ACK_RECEIVED = 1'b0;
    logic POLL_REQ;
    logic TIMER_RUNNING;
    int num_errors = 0;
    int total_checks = 0;
    int polls = 0;

    pctmr_top pctmr_top_i (.MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
        .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .IRQ(IRQ),
        .TXCLK_EFF(TXCLK_EFF), .FRAME_SYNC_INPUT(FRAME_SYNC_INPUT),
        .CLOCK_MODE5(CLOCK_MODE5), .IFRAME_SENT(IFRAME_SENT),
        .ACK_RECEIVED(ACK_RECEIVED), .POLL_REQ(POLL_REQ), .TIMER_RUNNING(TIMER_RUNNING));

    initial begin
        forever #10 MCLK = ~MCLK;
    end

    // one-cycle pulses are only seen by counting them at each edge
    always @(posedge MCLK) begin
        if (POLL_REQ === 1'b1) begin
            polls <= polls + 1;
        end
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR_STB <= 1'b1;
        @(posedge MCLK);
        WR_STB <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        RD_STB <= 1'b1;
        @(posedge MCLK);
        RD_STB <= 1'b0;
        #1 d = RDATA;
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(what, d, exp);
    endtask

    // pin high and low 4 cycles each, so the filter passes one edge and the tick lands
    task automatic ticks(input int n, input bit fs);
        repeat (n) begin
            @(posedge MCLK);
            FRAME_SYNC_INPUT <= fs;
            TXCLK_EFF <= !fs;
            repeat (4) @(posedge MCLK);
            FRAME_SYNC_INPUT <= 1'b0;
            TXCLK_EFF <= 1'b0;
            repeat (4) @(posedge MCLK);
        end
        repeat (2) @(posedge MCLK);
        #1;
    endtask

    task automatic pulse_engine(input bit ack);
        @(posedge MCLK);
        ACK_RECEIVED <= ack;
        IFRAME_SENT <= !ack;
        @(posedge MCLK);
        ACK_RECEIVED <= 1'b0;
        IFRAME_SENT <= 1'b0;
        repeat (2) @(posedge MCLK);
        #1;
    endtask

    task automatic test_regs;
        rdchk("cfg reset", `PCT_OFF_CFG, 8'h00);
        rdchk("val0 reset", `PCT_OFF_VAL0, 8'h00);
        wr(`PCT_OFF_VAL0, 8'hA5);
        wr(`PCT_OFF_VAL1, 8'h5A);
        wr(`PCT_OFF_VAL2, 8'hC3);
        wr(`PCT_OFF_CFG, 8'hFF);
        rdchk("val0", `PCT_OFF_VAL0, 8'hA5);
        rdchk("val1", `PCT_OFF_VAL1, 8'h5A);
        rdchk("val2", `PCT_OFF_VAL2, 8'hC3);
        rdchk("cfg fields", `PCT_OFF_CFG, 8'h97);
        rdchk("unmapped", 8'h3E, 8'h00);
        wr(`PCT_OFF_VAL1, 8'h00);
        wr(`PCT_OFF_VAL2, 8'h00);
        wr(`PCT_OFF_IMASK, 8'h07);
        rdchk("imask", `PCT_OFF_IMASK, 8'h07);
        $display("test regs done");
    endtask

    task automatic test_cpu_restart;
        wr(`PCT_OFF_VAL0, 8'h02);
        wr(`PCT_OFF_CFG, 8'h01);
        wr(`PCT_OFF_CMD, 8'h01);
        chk("running after start", TIMER_RUNNING, 1);
        rdchk("stat after start", `PCT_OFF_STAT, 8'h11);
        ticks(2, 0);
        chk("irq before period", IRQ, 0);
        ticks(1, 0);
        chk("irq at period", IRQ, 1);
        chk("restarted", TIMER_RUNNING, 1);
        rdchk("istat expiry", `PCT_OFF_ISTAT, 8'h01);
        chk("irq cleared", IRQ, 0);
        ticks(3, 0);
        chk("second expiry", IRQ, 1);
        chk("stopped at end", TIMER_RUNNING, 0);
        rdchk("istat second", `PCT_OFF_ISTAT, 8'h01);
        ticks(3, 0);
        chk("no third expiry", IRQ, 0);
        $display("test cpu restart done");
    endtask

    task automatic test_periodic_stop;
        wr(`PCT_OFF_VAL0, 8'h01);
        wr(`PCT_OFF_CFG, 8'h07);
        wr(`PCT_OFF_CMD, 8'h01);
        repeat (8) begin
            ticks(2, 0);
            rdchk("periodic istat", `PCT_OFF_ISTAT, 8'h01);
        end
        chk("still running", TIMER_RUNNING, 1);
        ticks(1, 0);
        wr(`PCT_OFF_CMD, 8'h02);
        chk("stopped", TIMER_RUNNING, 0);
        ticks(3, 0);
        chk("no irq after stop", IRQ, 0);
        $display("test periodic stop done");
    endtask

    task automatic test_source;
        wr(`PCT_OFF_VAL0, 8'h00);
        wr(`PCT_OFF_CFG, 8'h80);
        @(posedge MCLK);
        CLOCK_MODE5 <= 1'b1;
        wr(`PCT_OFF_CMD, 8'h01);
        ticks(1, 0);
        chk("tx ignored", IRQ, 0);
        ticks(1, 1);
        chk("frame sync expiry", IRQ, 1);
        rdchk("istat fs", `PCT_OFF_ISTAT, 8'h01);
        @(posedge MCLK);
        CLOCK_MODE5 <= 1'b0;
        wr(`PCT_OFF_CMD, 8'h01);
        ticks(1, 1);
        chk("fs outside mode5", IRQ, 0);
        ticks(1, 0);
        chk("tx expiry", IRQ, 1);
        rdchk("istat tx", `PCT_OFF_ISTAT, 8'h01);
        wr(`PCT_OFF_IMASK, 8'h00);
        wr(`PCT_OFF_CMD, 8'h01);
        ticks(1, 0);
        chk("masked irq", IRQ, 0);
        rdchk("istat masked", `PCT_OFF_ISTAT, 8'h01);
        wr(`PCT_OFF_IMASK, 8'h07);
        $display("test source done");
    endtask

    task automatic test_engine;
        int base;
        wr(`PCT_OFF_CFG, 8'h12);
        wr(`PCT_OFF_CMD, 8'h01);
        chk("cmd ignored", TIMER_RUNNING, 0);
        pulse_engine(0);
        chk("engine start", TIMER_RUNNING, 1);
        // poll counter has one driver; scenarios look at its growth only
        base = polls;
        ticks(2, 0);
        chk("two polls", 8'(polls - base), 8'h02);
        ticks(1, 0);
        chk("poll limit", 8'(polls - base), 8'h02);
        chk("engine stop", TIMER_RUNNING, 0);
        rdchk("istat engine", `PCT_OFF_ISTAT, 8'h06);
        wr(`PCT_OFF_CFG, 8'h17);
        pulse_engine(0);
        base = polls;
        ticks(8, 0);
        chk("endless polls", 8'(polls - base), 8'h08);
        chk("still polling", TIMER_RUNNING, 1);
        pulse_engine(1);
        chk("ack stops", TIMER_RUNNING, 0);
        $display("test engine done");
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge MCLK);
        SYS_RST <= 1'b0;
        test_regs();
        test_cpu_restart();
        test_periodic_stop();
        test_source();
        test_engine();
        final_report();
    end

    // whole run is under a thousand cycles; this allows well over ten times that
    initial begin
        #1000000;
        num_errors++;
        final_report();
    end
endmodule
`default_nettype wire
